// file: src/jdpa_pkg.sv
// jdpa_pkg: constants and types for the debug port access block
// assumes: shared by the top and the bench; no clock or reset of its own
package jdpa_pkg;
    // ==========================================================
    // timing
    localparam int MCLK_PERIOD_NS = 10;
    localparam int KEY_WINDOW_NS = 8000;
    localparam int KEY_WINDOW_CYC = KEY_WINDOW_NS / MCLK_PERIOD_NS;
    // ==========================================================
    // debug port selection held in the nonvolatile latch
    localparam logic [1:0] PSEL_JTAG4 = 2'h0;
    localparam logic [1:0] PSEL_JTAG5 = 2'h1;
    localparam logic [1:0] PSEL_SWD = 2'h2;
    localparam logic [1:0] PSEL_OFF = 2'h3;
    // ==========================================================
    // instruction register
    localparam int IR_W = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_IDCODE = 4'h1;
    localparam logic [3:0] INS_SAMPLE = 4'h2;
    localparam logic [3:0] INS_DEBUG = 4'h8;
    localparam logic [3:0] INS_RSTREG = 4'h9;
    localparam logic [3:0] INS_BYPASS = 4'hF;
    localparam int DR_W = 32;
    // ==========================================================
    // two-wire acquisition
    localparam int SWD_KEY_W = 16;
    localparam logic [2:0] SWD_ACK_OK = 3'h1;
    localparam logic [1:0] SWD_ACK_LEN = 2'h3;
    // ==========================================================
    // pins used per configuration
    localparam logic [2:0] PINS_NONE = 3'h0;
    localparam logic [2:0] PINS_TRACE = 3'h1;
    localparam logic [2:0] PINS_SWD = 3'h2;
    localparam logic [2:0] PINS_SWD_TRACE = 3'h3;
    localparam logic [2:0] PINS_JTAG4 = 3'h4;
    localparam logic [2:0] PINS_JTAG5 = 3'h5;
    // ==========================================================
    // test access port controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
        TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
        TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE,
        TAP_EX1_IR = 4'hA, TAP_PAU_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
    } jdpa_tap_type;
endpackage

// file: src/jdpa_sync.sv
// jdpa_sync: two-flop synchroniser for a bundle of independent levels
// assumes: each bit is a level held long enough to be seen on i_clk
`timescale 1ns/1ps
`default_nettype none
module jdpa_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic i_clk,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    // no reset: the pair settles within two edges
    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        o_q <= meta_r;
    end
endmodule
`default_nettype wire

// file: src/jdpa_seqdet.sv
// jdpa_seqdet: serial key detector, newest bit enters at the top
// assumes: i_bit is sampled on i_clk while i_en is high
`timescale 1ns/1ps
`default_nettype none
module jdpa_seqdet #(
    parameter int W = 16,
    parameter logic [W-1:0] KEY = '0
) (
    // clock and clear
    input wire logic i_clk,
    input wire logic i_clr,
    // serial data
    input wire logic i_en,
    input wire logic i_bit,
    output logic o_hit
);
    logic [W-1:0] sh_r;
    logic [W-1:0] sh_nxt;
    assign sh_nxt = {i_bit, sh_r[W-1:1]};
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            sh_r <= '0;
            o_hit <= 1'b0;
        end else if (i_en) begin
            sh_r <= sh_nxt;
            o_hit <= (sh_nxt == KEY);
        end else begin
            o_hit <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: src/jdpa_top.sv
// jdpa_top: programming and debug access port, boundary scan plus two-wire
// assumes: i_tck is made by the host and may stop; port selection and lock
// come from nonvolatile cells and are sampled while i_reset is high
`timescale 1ns/1ps
`default_nettype none
module jdpa_top
    import jdpa_pkg::*;
#(
    parameter int BSR_W = 8,
    parameter logic [31:0] ID_CODE = 32'h0000_1001, // arbitrary value
    parameter logic [15:0] ACQ_KEY = 16'hA55A,
    parameter logic [15:0] SW2J_KEY = 16'h3CC3
) (
    // system clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // nonvolatile settings and firmware controls
    input wire logic [1:0] i_debug_port_select,
    input wire logic i_wol_lock,
    input wire logic i_fw_debug_en,
    input wire logic i_fw_jtag_off,
    input wire logic i_fw_trace_en,
    // link pins
    input wire logic i_tck,
    input wire logic i_tms,
    output logic o_tms_o,
    output logic o_tms_oe,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic i_trst_n,
    // boundary cells (tck domain)
    input wire logic [BSR_W-1:0] i_bsr_pins,
    output logic [BSR_W-1:0] o_bsr_out,
    output logic o_bsr_extest,
    // system side status and requests
    output logic o_on_chip_debug,
    output logic o_jtag_pins_gpio,
    output logic [2:0] o_pins_used,
    output logic o_dbg_wr,
    output logic [31:0] o_dbg_data,
    output logic o_dev_rst_req
);
    // ==========================================================
    // system domain state
    logic [1:0] psel_r;
    logic lock_r;
    logic dbg_en_r;
    logic jtag_r;
    logic win_open_r;
    logic [9:0] win_cnt_r;
    logic dbg_prev_r;
    logic rst_prev_r;
    logic sw2j_prev_r;
    logic [3:0] m_s;
    logic m_dbg_tog;
    logic m_rst_tog;
    logic m_sw2j;
    logic m_swd_acq;
    logic swd_live;
    logic [2:0] pins_nxt;

    // tck domain state
    jdpa_tap_type tap_r;
    jdpa_tap_type tap_nxt;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] ir_r;
    logic [DR_W-1:0] dr_sr;
    logic [DR_W-1:0] dr_nxt;
    logic [DR_W-1:0] dbg_data_r;
    logic dbg_tog_r;
    logic rst_tog_r;
    logic swd_acq_r;
    logic sw2j_r;
    logic [1:0] ack_cnt_r;
    logic [6:0] t_s;
    logic trst_s;
    logic s_rst;
    logic s_lock;
    logic s_jtag;
    logic s_swd;
    logic s_trst_en;
    logic s_dbg_en;
    logic s_win;
    logic rst_t;
    logic acq_hit;
    logic sw2j_hit;
    logic [5:0] dr_len;
    logic [DR_W-1:0] dr_cap;

    // ==========================================================
    // crossings
    jdpa_sync #(.W(7)) u_to_tck (
        .i_clk(i_tck),
        .i_d({i_reset, lock_r, jtag_r, psel_r == PSEL_SWD && !lock_r,
              psel_r == PSEL_JTAG5, dbg_en_r, win_open_r}),
        .o_q(t_s)
    );
    jdpa_sync #(.W(1)) u_trst (
        .i_clk(i_tck),
        .i_d(i_trst_n),
        .o_q(trst_s)
    );
    jdpa_sync #(.W(4)) u_to_mclk (
        .i_clk(i_mclk),
        .i_d({dbg_tog_r, rst_tog_r, sw2j_r, swd_acq_r}),
        .o_q(m_s)
    );
    assign {s_rst, s_lock, s_jtag, s_swd, s_trst_en, s_dbg_en, s_win} = t_s;
    assign {m_dbg_tog, m_rst_tog, m_sw2j, m_swd_acq} = m_s;

    // ==========================================================
    // system domain: selection, lock, debug enable, pins
    assign swd_live = m_swd_acq && !jtag_r && !lock_r;
    assign pins_nxt = lock_r ? PINS_NONE :
                      jtag_r ? ((psel_r == PSEL_JTAG5) ? PINS_JTAG5 : PINS_JTAG4) :
                      swd_live ? (i_fw_trace_en ? PINS_SWD_TRACE : PINS_SWD) :
                      (i_fw_trace_en && psel_r != PSEL_OFF) ? PINS_TRACE : PINS_NONE;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            psel_r <= i_debug_port_select;
            lock_r <= i_wol_lock;
            dbg_en_r <= 1'b0;
            jtag_r <= !i_wol_lock && (i_debug_port_select == PSEL_JTAG4 ||
                      i_debug_port_select == PSEL_JTAG5);
            win_cnt_r <= 10'(KEY_WINDOW_CYC);
            win_open_r <= 1'b1;
        end else begin
            dbg_en_r <= dbg_en_r || (i_fw_debug_en && !lock_r);
            if (i_fw_jtag_off) begin
                jtag_r <= 1'b0;
            end else if (m_sw2j && !sw2j_prev_r && !lock_r) begin
                jtag_r <= 1'b1;
            end
            if (win_cnt_r != 10'h000) begin
                win_cnt_r <= win_cnt_r - 10'h001;
            end
            win_open_r <= (win_cnt_r > 10'h001);
        end
    end

    // edge detectors preload the synced level so reset makes no false pulse
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            dbg_prev_r <= m_dbg_tog;
            rst_prev_r <= m_rst_tog;
            sw2j_prev_r <= m_sw2j;
            o_dbg_wr <= 1'b0;
            o_dbg_data <= 32'h0000_0000;
            o_dev_rst_req <= 1'b0;
            o_on_chip_debug <= 1'b0;
            o_jtag_pins_gpio <= 1'b0;
            o_pins_used <= PINS_NONE;
        end else begin
            dbg_prev_r <= m_dbg_tog;
            rst_prev_r <= m_rst_tog;
            sw2j_prev_r <= m_sw2j;
            o_dbg_wr <= (m_dbg_tog != dbg_prev_r) && dbg_en_r && !lock_r;
            if (m_dbg_tog != dbg_prev_r) begin
                o_dbg_data <= dbg_data_r;
            end
            o_dev_rst_req <= (m_rst_tog != rst_prev_r) && psel_r != PSEL_OFF && !lock_r;
            o_on_chip_debug <= dbg_en_r;
            o_jtag_pins_gpio <= !jtag_r && !swd_live;
            o_pins_used <= pins_nxt;
        end
    end

    // ==========================================================
    // tck domain: controller reset and state machine
    // held in reset on system reset, while locked, while not in scan mode, or on test reset when the five-pin port is selected
    assign rst_t = s_rst || s_lock || !s_jtag || (s_trst_en && !trst_s);

    always_comb begin
        case (tap_r)
            TAP_RESET: tap_nxt = i_tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_nxt = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_nxt = i_tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_nxt = i_tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_nxt = i_tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_nxt = i_tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_nxt = i_tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_nxt = i_tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_nxt = i_tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_nxt = i_tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_nxt = i_tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_nxt = i_tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_nxt = i_tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            default: tap_nxt = TAP_RESET;
        endcase
    end

    // ==========================================================
    // data register selection, length and capture
    assign dr_len = (ir_r == INS_IDCODE || ir_r == INS_DEBUG) ? 6'd32 :
                    (ir_r == INS_EXTEST || ir_r == INS_SAMPLE) ? 6'(BSR_W) :
                    6'd1;
    assign dr_cap = (ir_r == INS_IDCODE) ? ID_CODE :
                    (ir_r == INS_DEBUG) ? dbg_data_r :
                    (ir_r == INS_EXTEST || ir_r == INS_SAMPLE) ? DR_W'(i_bsr_pins) :
                    '0;

    // shift toward tdo, new bit enters at the selected length
    always_comb begin
        dr_nxt = dr_sr >> 1;
        for (int i = 0; i < DR_W; i++) begin
            if (6'(i) == dr_len - 6'd1) begin
                dr_nxt[i] = i_tdi;
            end
        end
    end

    always_ff @(posedge i_tck) begin
        if (rst_t) begin
            tap_r <= TAP_RESET;
            ir_sr <= IR_CAPTURE;
            ir_r <= INS_IDCODE;
            dr_sr <= '0;
        end else begin
            tap_r <= tap_nxt;
            case (tap_r)
                TAP_RESET: ir_r <= INS_IDCODE;
                TAP_CAP_IR: ir_sr <= IR_CAPTURE;
                TAP_SH_IR: ir_sr <= {i_tdi, ir_sr[IR_W-1:1]};
                TAP_UPD_IR: ir_r <= ir_sr;
                TAP_CAP_DR: dr_sr <= dr_cap;
                TAP_SH_DR: dr_sr <= dr_nxt;
                default: ;
            endcase
        end
    end

    // update effects: boundary drive, debug word, device reset
    always_ff @(posedge i_tck) begin
        if (s_rst) begin
            o_bsr_out <= '0;
            o_bsr_extest <= 1'b0;
            dbg_data_r <= '0;
            dbg_tog_r <= 1'b0;
            rst_tog_r <= 1'b0;
        end else begin
            o_bsr_extest <= !rst_t && ir_r == INS_EXTEST;
            if (!rst_t && tap_r == TAP_UPD_DR) begin
                if (ir_r == INS_EXTEST || ir_r == INS_SAMPLE) begin
                    o_bsr_out <= dr_sr[BSR_W-1:0];
                end
                if (ir_r == INS_DEBUG && s_dbg_en) begin
                    dbg_data_r <= dr_sr;
                    dbg_tog_r <= !dbg_tog_r;
                end
                if (ir_r == INS_RSTREG && dr_sr[0]) begin
                    rst_tog_r <= !rst_tog_r;
                end
            end
        end
    end

    // tdo changes on the falling edge
    always_ff @(negedge i_tck) begin
        if (rst_t) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo <= (tap_r == TAP_SH_IR) ? ir_sr[0] : dr_sr[0];
            o_tdo_oe <= tap_r == TAP_SH_IR || tap_r == TAP_SH_DR;
        end
    end

    // ==========================================================
    // two-wire acquisition on the mode and clock pins
    jdpa_seqdet #(.W(SWD_KEY_W), .KEY(ACQ_KEY)) u_acq (
        .i_clk(i_tck),
        .i_clr(s_rst || !s_swd),
        .i_en(s_win && !swd_acq_r),
        .i_bit(i_tms),
        .o_hit(acq_hit)
    );
    jdpa_seqdet #(.W(SWD_KEY_W), .KEY(SW2J_KEY)) u_sw2j (
        .i_clk(i_tck),
        .i_clr(s_rst || !swd_acq_r),
        .i_en(swd_acq_r && !sw2j_r && ack_cnt_r == 2'h0),
        .i_bit(i_tms),
        .o_hit(sw2j_hit)
    );

    always_ff @(posedge i_tck) begin
        if (s_rst || !s_swd) begin
            swd_acq_r <= 1'b0;
            sw2j_r <= 1'b0;
            ack_cnt_r <= 2'h0;
            o_tms_o <= 1'b0;
            o_tms_oe <= 1'b0;
        end else begin
            if (acq_hit && !swd_acq_r) begin
                swd_acq_r <= 1'b1;
                ack_cnt_r <= SWD_ACK_LEN;
            end else if (ack_cnt_r != 2'h0) begin
                ack_cnt_r <= ack_cnt_r - 2'h1;
            end
            if (sw2j_hit) begin
                sw2j_r <= 1'b1;
            end
            // mode pin driven only for the acknowledge before switching
            o_tms_oe <= ack_cnt_r != 2'h0 && !sw2j_r;
            o_tms_o <= SWD_ACK_OK[2'(SWD_ACK_LEN - ack_cnt_r)];
        end
    end

    // ==========================================================
    // checks
    tlr_reach_a:
    assert property (@(posedge i_tck) disable iff (rst_t)
        i_tms [*5] |=> tap_r == TAP_RESET)
        else $error("controller not in reset after five mode-high clocks");
    bsr_hold_a:
    assert property (@(posedge i_tck) disable iff (s_rst)
        !s_jtag |=> $stable(o_bsr_out))
        else $error("boundary outputs changed outside scan mode");
    pins_lock_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
        lock_r |=> o_pins_used == PINS_NONE)
        else $error("pins in use while locked");
    gpio_rel_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
        i_fw_jtag_off && !m_swd_acq ##1 !m_swd_acq |=> o_jtag_pins_gpio)
        else $error("scan pins not released after firmware disable");
    dbg_en_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
        !dbg_en_r && !i_fw_debug_en |=> !dbg_en_r ##1 !o_on_chip_debug)
        else $error("on-chip debug enabled without firmware");
    lock_off_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
        lock_r |-> !o_dbg_wr && !o_dev_rst_req && !jtag_r)
        else $error("access while locked");
    tms_dir_a:
    assert property (@(posedge i_tck) disable iff (s_rst)
        o_tms_oe |-> $past(s_swd) && !$past(sw2j_r) && !$past(s_jtag))
        else $error("mode pin driven outside two-wire acquisition");
    rst_reg_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
        o_dev_rst_req |-> psel_r != PSEL_OFF && $past(m_rst_tog) != $past(rst_prev_r))
        else $error("device reset without request or when ports disabled");
    psel_rd_a:
    assert property (@(posedge i_mclk)
        $past(i_reset) |-> psel_r == $past(i_debug_port_select) || !i_reset)
        else $error("port selection not captured at reset");
endmodule
`default_nettype wire

// file: tb/jdpa_host.sv
// jdpa_host: behavioural host programmer on the scan and two-wire pins
// assumes: the bench resolves the shared mode pin from both drivers
`timescale 1ns/1ps
`default_nettype none
module jdpa_host (
    // pins driven by the host
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n,
    // pins seen by the host
    input wire logic i_tms_wire,
    input wire logic i_tms_oe,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    logic [2:0] ack;
    int oe_cycles;
    int tdo_oe_cycles;
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b1;
        ack = 3'h0;
        oe_cycles = 0;
        tdo_oe_cycles = 0;
    end
    // ==========================================================
    // link clock: idles low between frames, 80 ns period
    task automatic clk_bit(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #40 o_tck = 1'b1;
        #39 tdo = i_tdo;
        if (i_tms_oe) begin
            oe_cycles++;
            ack = {i_tms_wire, ack[2:1]};
        end
        if (i_tdo_oe) begin
            tdo_oe_cycles++;
        end
        #1 o_tck = 1'b0;
    endtask
    task automatic run(input int n, input logic tms);
        logic q;
        for (int i = 0; i < n; i++) begin
            clk_bit(tms, 1'b0, q);
        end
    endtask
    // ==========================================================
    // frames
    task automatic tap_reset();
        run(5, 1'b1);
        run(1, 1'b0);
    endtask
    // shift n bits lsb first through ir or dr, idle to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        run(1, 1'b1);
        if (ir) begin
            run(1, 1'b1);
        end
        run(2, 1'b0);
        for (int i = 0; i < n; i++) begin
            clk_bit(i == n - 1, din[i], q);
            dout[i] = q;
        end
        run(1, 1'b1);
        run(1, 1'b0);
        o_tdi = ~o_tdi;
    endtask
    task automatic send_key(input logic [15:0] key);
        logic q;
        for (int i = 0; i < 16; i++) begin
            clk_bit(key[i], 1'b0, q);
        end
    endtask
    task automatic trst_pulse();
        o_trst_n = 1'b0;
        run(4, 1'b0);
        o_trst_n = 1'b1;
        run(4, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// tb: self-checking bench for the debug port access block
// assumes: host model drives the link; bench drives the system side
`timescale 1ns/1ps
`default_nettype none
module tb
    import jdpa_pkg::*;
;
    localparam int BW = 8;
    localparam logic [31:0] TB_ID = 32'h0000_1001; // arbitrary value
    localparam logic [15:0] ACQ_KEY_TB = 16'hA55A;
    localparam logic [15:0] SW2J_KEY_TB = 16'h3CC3;
    logic i_mclk, i_reset, lock, dbg_en, jtag_off, trace_en;
    logic [1:0] sel;
    logic tck, host_tms, tms_wire, tdi, trst_n, tms_o, tms_oe, tdo, tdo_oe;
    logic [BW-1:0] bsr_pins, bsr_out;
    logic bsr_extest, dbg_on, gpio, dbg_wr, rst_req;
    logic [2:0] pins;
    logic [31:0] dbg_data;
    logic [15:0] lfsr_state;
    logic [31:0] exp_q[$];
    int mismatches, total_checks, wr_seen, rst_seen, cyc;

    assign tms_wire = tms_oe ? tms_o : host_tms;

    jdpa_top #(.BSR_W(BW), .ID_CODE(TB_ID)) DUT (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_debug_port_select(sel), .i_wol_lock(lock),
        .i_fw_debug_en(dbg_en), .i_fw_jtag_off(jtag_off), .i_fw_trace_en(trace_en),
        .i_tck(tck), .i_tms(tms_wire), .o_tms_o(tms_o), .o_tms_oe(tms_oe), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_trst_n(trst_n), .i_bsr_pins(bsr_pins),
        .o_bsr_out(bsr_out), .o_bsr_extest(bsr_extest), .o_on_chip_debug(dbg_on),
        .o_jtag_pins_gpio(gpio), .o_pins_used(pins), .o_dbg_wr(dbg_wr),
        .o_dbg_data(dbg_data), .o_dev_rst_req(rst_req)
    );
    jdpa_host host (
        .o_tck(tck), .o_tms(host_tms), .o_tdi(tdi), .o_trst_n(trst_n),
        .i_tms_wire(tms_wire), .i_tms_oe(tms_oe), .i_tdo(tdo), .i_tdo_oe(tdo_oe)
    );

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // ==========================================================
    // helpers
    task automatic check_val(input string name, input logic [31:0] exp,
                             input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_mclk(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic pulse(ref logic s);
        @(negedge i_mclk);
        s = 1'b1;
        @(negedge i_mclk);
        s = 1'b0;
        wait_mclk(3);
    endtask
    function automatic logic [31:0] rnd();
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            lfsr_state = {lfsr_state[14:0],
                          lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
            r[i] = lfsr_state[0];
        end
        return r;
    endfunction
    // tck keeps running through reset so the link side resets too
    task automatic do_reset(input logic [1:0] s, input logic lk);
        @(negedge i_mclk);
        i_reset = 1'b1;
        sel = s;
        lock = lk;
        wait_mclk(4);
        #3;
        host.run(4, 1'b1);
        @(negedge i_mclk);
        i_reset = 1'b0;
        host.run(5, 1'b1);
        host.run(1, 1'b0);
        wait_mclk(4);
    endtask
    // debug words are matched in order against the expected queue
    // sampled mid-cycle so one-cycle pulses are seen settled
    always @(negedge i_mclk) begin
        if (dbg_wr === 1'b1) begin
            wr_seen++;
            if (exp_q.size() > 0) begin
                check_val("dbg_data", exp_q.pop_front(), dbg_data);
            end
        end
        if (rst_req === 1'b1) begin
            rst_seen++;
        end
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            stop_test();
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        logic [31:0] d;
        logic [31:0] w;
        int base;
        lfsr_state = 16'h089B;
        mismatches = 0;
        total_checks = 0;
        wr_seen = 0;
        rst_seen = 0;
        cyc = 0;
        i_reset = 1'b1;
        {lock, dbg_en, jtag_off, trace_en} = 4'h0;
        sel = PSEL_JTAG4;
        bsr_pins = 8'h00;
        do_reset(PSEL_JTAG4, 1'b0);
        check_val("pins_jtag4", 32'(PINS_JTAG4), 32'(pins));
        check_val("debug_off", 32'h0, 32'(dbg_on));
        check_val("gpio_off", 32'h0, 32'(gpio));
        host.scan(1'b0, DR_W, 32'h0, d);
        check_val("idcode", TB_ID, d);
        host.scan(1'b1, IR_W, 32'(INS_DEBUG), d);
        check_val("ir_capture", 32'(IR_CAPTURE), 32'(d[IR_W-1:0]));
        host.scan(1'b0, DR_W, rnd(), d);
        wait_mclk(10);
        check_val("wr_refused", 32'h0, 32'(wr_seen));
        pulse(dbg_en);
        check_val("debug_on", 32'h1, 32'(dbg_on));
        for (int k = 0; k < 2; k++) begin
            w = rnd();
            exp_q.push_back(w);
            host.scan(1'b0, DR_W, w, d);
        end
        wait_mclk(10);
        check_val("wr_count", 32'h2, 32'(wr_seen));
        host.scan(1'b1, IR_W, 32'(INS_RSTREG), d);
        host.scan(1'b0, 1, 32'h1, d);
        wait_mclk(10);
        check_val("rst_req", 32'h1, 32'(rst_seen));
        w = rnd();
        bsr_pins = w[BW-1:0];
        host.scan(1'b1, IR_W, 32'(INS_SAMPLE), d);
        host.scan(1'b0, BW, 32'h0, d);
        check_val("bsr_sample", 32'(bsr_pins), d);
        host.scan(1'b1, IR_W, 32'(INS_EXTEST), d);
        w = rnd();
        host.scan(1'b0, BW, w, d);
        check_val("extest", 32'h1, 32'(bsr_extest));
        check_val("bsr_out", 32'(w[BW-1:0]), 32'(bsr_out));
        host.scan(1'b1, IR_W, 32'(INS_BYPASS), d);
        host.scan(1'b0, 2, 32'h1, d);
        check_val("bypass", 32'h2, d);
        check_val("tms_in_only", 32'h0, 32'(host.oe_cycles));
        pulse(jtag_off);
        check_val("gpio_on", 32'h1, 32'(gpio));
        base = host.tdo_oe_cycles;
        host.scan(1'b0, DR_W, 32'h0, d);
        check_val("tdo_released", 32'(base), 32'(host.tdo_oe_cycles));
        do_reset(PSEL_JTAG4, 1'b1);
        base = host.tdo_oe_cycles;
        host.scan(1'b1, IR_W, 32'(INS_RSTREG), d);
        host.scan(1'b0, 1, 32'h1, d);
        wait_mclk(10);
        check_val("lock_tdo", 32'(base), 32'(host.tdo_oe_cycles));
        check_val("lock_rst", 32'h1, 32'(rst_seen));
        do_reset(PSEL_OFF, 1'b0);
        check_val("pins_off", 32'(PINS_NONE), 32'(pins));
        host.scan(1'b1, IR_W, 32'(INS_RSTREG), d);
        host.scan(1'b0, 1, 32'h1, d);
        wait_mclk(10);
        check_val("off_rst", 32'h1, 32'(rst_seen));
        do_reset(PSEL_JTAG5, 1'b0);
        check_val("pins_jtag5", 32'(PINS_JTAG5), 32'(pins));
        host.scan(1'b1, IR_W, 32'(INS_BYPASS), d);
        host.trst_pulse();
        host.scan(1'b0, DR_W, 32'h0, d);
        check_val("trst_idcode", TB_ID, d);
        do_reset(PSEL_SWD, 1'b0);
        host.send_key(ACQ_KEY_TB);
        host.run(6, 1'b1);
        check_val("ack_len", 32'(SWD_ACK_LEN), 32'(host.oe_cycles));
        check_val("ack_bits", 32'(SWD_ACK_OK), 32'(host.ack));
        wait_mclk(3);
        check_val("pins_swd", 32'(PINS_SWD), 32'(pins));
        @(negedge i_mclk);
        trace_en = 1'b1;
        wait_mclk(3);
        check_val("pins_trace", 32'(PINS_SWD_TRACE), 32'(pins));
        trace_en = 1'b0;
        host.send_key(SW2J_KEY_TB);
        host.run(4, 1'b1);
        wait_mclk(20);
        host.tap_reset();
        host.scan(1'b0, DR_W, 32'h0, d);
        check_val("swd_to_scan", TB_ID, d);
        check_val("tms_in_again", 32'(SWD_ACK_LEN), 32'(host.oe_cycles));
        stop_test();
    end
endmodule
`default_nettype wire
